/* File: shared/cpcd_pkg.sv */
// package: register map, field layout and rate constants of the clock divider
package cpcd_pkg;
  localparam int          CPCD_ADDR_W       = 12;
  localparam logic [11:0] CPCD_CLK_CTRL_IDX = 12'h08F;
  localparam logic [11:0] CPCD_PLL_DIV_IDX  = 12'h090;
  localparam logic [11:0] CPCD_CLK_CTRL_OFF = 12'h23C;
  localparam logic [11:0] CPCD_PLL_DIV_OFF  = 12'h240;
  localparam logic [7:0]  CPCD_CLK_CTRL_RST = 8'h00;
  localparam logic [7:0]  CPCD_PLL_DIV_RST  = 8'h00;
  localparam int          CPCD_DS_BIT       = 0;
  localparam int          CPCD_PER_LSB      = 1;
  localparam int          CPCD_NUM_PER      = 7;
  localparam int          CPCD_R_LSB        = 4;
  localparam int          CPCD_N_LSB        = 0;
  localparam int          CPCD_FIELD_W      = 4;
  localparam int          CPCD_FAST_PERIODS = 6;
  localparam int          CPCD_SLOW_PERIODS = 12;
  localparam logic [3:0]  CPCD_CNT_ZERO     = 4'h0;
  localparam logic [3:0]  CPCD_CNT_ONE      = 4'h1;
endpackage

/* File: shared/cpcd_rate_if.sv */
// interface: one rate request and the enable pulse it yields
`timescale 1ns/100ps
`default_nettype none
interface cpcd_rate_if;
  logic slow;
  logic tick;
  modport ctrl (output slow, input tick);
  modport gen  (input slow, output tick);
endinterface
`default_nettype wire

/* File: src/cpcd_tick_gen.sv */
// module: enable pulse every 6 or 12 oscillator periods
`timescale 1ns/100ps
`default_nettype none
module cpcd_tick_gen (
  input  wire logic   pclk,
  input  wire logic   presetn,
  cpcd_rate_if.gen    rate
);
  import cpcd_pkg::*;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] last;
  logic       tick_reg;
  logic       tick_next;

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  always_comb begin
    last = rate.slow ? 4'(CPCD_SLOW_PERIODS - 1) : 4'(CPCD_FAST_PERIODS - 1);
    // a rate change mid-period finishes early rather than overshoots
    if (cnt_reg >= last) begin
      cnt_next = CPCD_CNT_ZERO;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + CPCD_CNT_ONE;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= CPCD_CNT_ZERO;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign rate.tick = tick_reg;
endmodule
`default_nettype wire

/* File: src/cpcd_top.sv */
// module: clock rate control registers on apb with per-peripheral enables
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - peripheral selects ignored while double speed off
// - double speed: clear 12, set 6 periods for the cpu
// - control register bits: peripherals 7..1, speed 0
// - pll divider: R bits 7-4, N 3-0
module cpcd_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [cpcd_pkg::CPCD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic                             cpu_tick,
  output logic      [cpcd_pkg::CPCD_NUM_PER-1:0] periph_tick,
  output logic      [3:0]                  pll_r_divider_field,
  output logic      [3:0]                  pll_n_divider_field
);
  import cpcd_pkg::*;

  logic [7:0]  clock_speed_control_reg;
  logic [7:0]  clock_speed_control_next;
  logic [7:0]  pll_divider_setting_reg;
  logic [7:0]  pll_divider_setting_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        access;
  logic        hit_ctrl;
  logic        hit_pll;
  logic        double_speed_select;
  logic [CPCD_NUM_PER-1:0] rate_select;

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  assign access   = psel & penable;
  assign hit_ctrl = (paddr == CPCD_CLK_CTRL_OFF);
  assign hit_pll  = (paddr == CPCD_PLL_DIV_OFF);

  always_comb begin
    clock_speed_control_next = clock_speed_control_reg;
    pll_divider_setting_next = pll_divider_setting_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      // read data staged in setup so it stands in the access cycle
      prdata_next = 32'h0000_0000;
      if (!pwrite && hit_ctrl) begin
        prdata_next[7:0] = clock_speed_control_reg;
      end else if (!pwrite && hit_pll) begin
        prdata_next[7:0] = pll_divider_setting_reg;
      end
      pslverr_next = !(hit_ctrl || hit_pll);
    end
    if (access && pwrite) begin
      if (hit_ctrl) begin
        clock_speed_control_next = pwdata[7:0];
      end else if (hit_pll) begin
        pll_divider_setting_next = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_speed_control_reg <= CPCD_CLK_CTRL_RST;
      pll_divider_setting_reg <= CPCD_PLL_DIV_RST;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      clock_speed_control_reg <= clock_speed_control_next;
      pll_divider_setting_reg <= pll_divider_setting_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg & access;

  // ----------------------------------------------------------------
  // rate selection
  // ----------------------------------------------------------------
  assign double_speed_select = clock_speed_control_reg[CPCD_DS_BIT];
  assign pll_r_divider_field =
    pll_divider_setting_reg[CPCD_R_LSB +: CPCD_FIELD_W];
  assign pll_n_divider_field =
    pll_divider_setting_reg[CPCD_N_LSB +: CPCD_FIELD_W];

  // peripheral selects only count while double speed is on
  assign rate_select = double_speed_select ?
    clock_speed_control_reg[CPCD_PER_LSB +: CPCD_NUM_PER] :
    {CPCD_NUM_PER{1'b1}};

  cpcd_rate_if cpu_if ();
  assign cpu_if.slow = ~double_speed_select;
  assign cpu_tick    = cpu_if.tick;
  cpcd_tick_gen u_cpu (
    .pclk    (pclk),
    .presetn (presetn),
    .rate    (cpu_if.gen)
  );

  // bit order: 0 timer0, 1 timer1, 2 timer2, 3 serial, 4 counter array,
  // 5 watchdog, 6 two-wire
  genvar g;
  generate
    for (g = 0; g < CPCD_NUM_PER; g++) begin : g_per
      cpcd_rate_if per_if ();
      assign per_if.slow    = rate_select[g];
      assign periph_tick[g] = per_if.tick;
      cpcd_tick_gen u_per (
        .pclk    (pclk),
        .presetn (presetn),
        .rate    (per_if.gen)
      );
    end
  endgenerate
endmodule
`default_nettype wire

/* File: verification/cpcd_properties.sv */
// checker: register and tick-rate properties of cpcd_top
`timescale 1ns/100ps
`default_nettype none
module cpcd_checker import cpcd_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        cpu_tick,
  input wire logic [6:0]  periph_tick,
  input wire logic [3:0]  pll_r_divider_field,
  input wire logic [3:0]  pll_n_divider_field
);
  // ----------------------------------------------------------
  // speed byte mirror; stb counts cycles since it last changed, holding at 15
  // ----------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] ctl;
  logic [3:0] stb;
  wire        rd = psel && penable && !pwrite;
  wire        cw = psel && penable && pwrite && paddr == CPCD_CLK_CTRL_OFF;
  wire        pw = psel && penable && pwrite && paddr == CPCD_PLL_DIV_OFF;
  wire  [6:0] f  = {7{ctl[0]}} & ~ctl[7:1];
  wire  [7:0] pf = {pll_r_divider_field, pll_n_divider_field};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      stb <= 4'h0;
    end else begin
      ctl <= cw ? pwdata[7:0] : ctl;
      // period checks wait until a rate change has settled
      stb <= (cw && pwdata[7:0] != ctl) ? 4'h0 : stb + {3'h0, stb != 4'hF};
    end
  end
  tick_gap_a: assert property (cpu_tick |=> !cpu_tick [*5])
    else $error("cpu tick too soon");
  cpu_fast_a: assert property (stb > 4'h6 && ctl[0] |->
    cpu_tick == $past(cpu_tick, 6)) else $error("cpu fast period");
  cpu_slow_a: assert property (stb > 4'hC && !ctl[0] |->
    cpu_tick == $past(cpu_tick, 12)) else $error("cpu slow period");
  per_fast_a: assert property (stb > 4'h6 |->
    (periph_tick & f) == ($past(periph_tick, 6) & f)) else $error("fast");
  per_slow_a: assert property (stb > 4'hC |->
    (periph_tick & ~f) == ($past(periph_tick, 12) & ~f)) else $error("slow");
  ctl_read_a: assert property (rd && paddr == CPCD_CLK_CTRL_OFF |->
    prdata == {24'h0, ctl}) else $error("speed byte read");
  pll_read_a: assert property (rd && paddr == CPCD_PLL_DIV_OFF |->
    prdata == {24'h0, pf}) else $error("pll read");
  pll_write_a: assert property (pw |=> pf == $past(pwdata[7:0]))
    else $error("pll fields");
  cover property (cw && pwdata[0]);
  cover property (cpu_tick && ctl[0]);
  cover property (pw);
endmodule
bind cpcd_top cpcd_checker u_chk (.*);
`default_nettype wire

/* File: verification/cpcd_top_test.sv */
// testbench: register traffic and tick-rate counts for cpcd_top
`timescale 1ns/100ps
`default_nettype none
module cpcd_top_test;
  import cpcd_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, cpu_tick, er;
  logic [6:0]  periph_tick;
  logic [3:0]  pll_r_divider_field, pll_n_divider_field;
  logic [7:0]  v;
  int          error_cnt = 0, num_checks = 0, cnt[8];
  always #2 pclk = ~pclk;
  cpcd_top u_dut (.*);
  // ----------------------------------------------------------
  // bus, compare and rate helpers
  // ----------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", s, e, g);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // 120 cycles hold a whole number of both periods, so phase drops out
  task automatic count();
    cnt = '{default: 0};
    repeat (24) @(posedge pclk);
    repeat (120) begin
      @(posedge pclk);
      cnt[7] += (cpu_tick === 1'b1);
      for (int k = 0; k < 7; k++) cnt[k] += (periph_tick[k] === 1'b1);
    end
  endtask
  function automatic logic [31:0] per(input logic [7:0] c, input int k);
    return (c[0] && (k == 7 || !c[k+1])) ? 32'h14 : 32'hA;
  endfunction
  initial begin
    void'($urandom(32'hF454));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CPCD_CLK_CTRL_OFF, 32'h0);
    chk("ctl reset", {24'h0, CPCD_CLK_CTRL_RST}, rd);
    apb(1'b0, CPCD_PLL_DIV_OFF, 32'h0);
    chk("pll reset", 32'h0, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    for (int i = 0; i < 7; i++) begin
      v = i == 0 ? 8'hFF : i == 1 ? 8'hFE : i == 2 ? 8'h01 : 8'($urandom);
      apb(1'b1, CPCD_CLK_CTRL_OFF, {24'($urandom), v});
      apb(1'b0, CPCD_CLK_CTRL_OFF, 32'h0);
      chk("ctl", {24'h0, v}, rd);
      count();
      for (int k = 0; k < 8; k++) chk("rate", per(v, k), cnt[k]);
      apb(1'b1, CPCD_PLL_DIV_OFF, {24'h0, ~v});
      apb(1'b0, CPCD_PLL_DIV_OFF, 32'h0);
      chk("pll", {24'h0, ~v}, {rd[31:8], pll_r_divider_field, pll_n_divider_field});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
